// File: rtl/scl_pkg.sv
/*
 * constants of the switch configuration loader: timing, strap layout,
 * decode values and register map.
 * assumes one system clock that is also the input port clock.
 */
package scl_pkg;
   // serial line timing, in input port clock periods
   localparam int unsigned BIT_CYCLES  = 5;  // one serial bit
   localparam int unsigned HALF_CYCLES = 2;  // fall to bit centre
   localparam int unsigned CFG_BITS    = 14; // settings per frame
   localparam int unsigned DETECT_DEF  = 16; // window to spot a clock
   // strap / frame layout, msb sent first
   localparam int unsigned SIZE_LSB  = 12;
   localparam int unsigned LOC_LSB   = 8;
   localparam int unsigned COL_LSB   = 5;
   localparam int unsigned SPLIT_BIT = 4;
   localparam int unsigned NOTE_BIT  = 3;
   localparam int unsigned THR_LSB   = 1;
   localparam int unsigned MODE_BIT  = 0;
   // decode values
   localparam logic [6:0] LOW_SPLIT   = 7'h32; // 50 cells
   localparam logic [6:0] HIGH_SPLIT  = 7'h19; // 25 cells
   localparam logic [6:0] SINGLE_Q    = 7'h4b; // 75 cells
   localparam logic [6:0] PCT_20      = 7'h14;
   localparam logic [6:0] PCT_50      = 7'h32;
   localparam logic [6:0] PCT_80      = 7'h50;
   // register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_CONFIG  = 8'h08;
   localparam logic [7:0] REG_DECODE  = 8'h0c;
   localparam logic       SER_IDLE    = 1'b1;  // line level at rest
   // states, gray along reset-detect-load-send-done
   typedef enum logic [3:0] {
      ST_RESET  = 4'h0,
      ST_SETTLE = 4'h1,
      ST_DETECT = 4'h3,
      ST_LOAD   = 4'h2,
      ST_TX     = 4'h6,
      ST_DONE   = 4'h7,
      ST_HUNT   = 4'hb,
      ST_START  = 4'h9,
      ST_RX     = 4'h8
   } scl_state_t;
endpackage : scl_pkg

// File: rtl/scl_loader.sv
/*
 * configuration manager of a 4x4 cell switch element: reset cycle,
 * master/slave detection, strap capture, serial send and receive,
 * decode of the settings, and a wishbone classic register slave.
 * assumes all inputs are synchronous to sys_clk, which is the input
 * port clock; the expansion clock is only sampled, never used as clock.
 */
// The implementer's own choices: the Wishbone register port and the address map.
// Functional notes
// - internal reset synchronous; init follows reset
// - outputs inactive one clock after reset
// - reset cycle ends two clocks later
// - idle expansion clock means master, else slave
// - master captures fourteen straps after reset
// - size code gives width two to five
// - location code picks field start position
// - column code selects group of four columns
// - queue bit: split 50/25 or single 75
// - notify strap enables congestion marking everywhere
// - threshold codes 1-3 map to 20/50/80 percent, code 0 gives 0
// - stream strap high selects utopia mode
// - vendor mode: outputs change on falling edge
// - utopia mode: outputs change on rising edge
// - serial bit lasts five input clocks
// - master sends low start bit first
// - master holds line high after frame
// - slave confirms start low at bit centre
// - slave samples every five clocks after centre
// - slave ignores line once configured
// - reset drives serial output high
// - master ignores its serial input entirely
module scl_loader #(
   parameter int unsigned DETECT_CYCLES = scl_pkg::DETECT_DEF
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        expansion_clock,
   input  wire logic [13:0] exp_straps,
   input  wire logic        cfg_serial_in,
   output logic             cfg_serial_out,
   output logic             cfg_valid,
   output logic             is_master,
   output logic [13:0]      cfg_word,
   output logic [2:0]       field_width,
   output logic [4:0]       field_start,
   output logic             field_valid,
   output logic [5:0]       column_first,
   output logic [6:0]       low_queue_cells,
   output logic [6:0]       high_queue_cells,
   output logic             congestion_notify_en,
   output logic [6:0]       threshold_pct,
   output logic             utopia_stream_mode,
   output logic             vendor_stream_mode,
   output logic             out_on_falling,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   localparam int DW = $clog2(DETECT_CYCLES + 1);

   scl_pkg::scl_state_t state;        // sequencer state
   scl_pkg::scl_state_t next_state;
   logic [2:0]          div_cnt;      // clocks within a serial bit
   logic [2:0]          next_div_cnt;
   logic [3:0]          bit_cnt;      // bits sent or received
   logic [3:0]          next_bit_cnt;
   logic [DW-1:0]       det_cnt;      // detection window counter
   logic [DW-1:0]       next_det_cnt;
   logic                exp_q;        // previous expansion clock sample
   logic [13:0]         shift;        // serial shift register
   logic [13:0]         next_shift;
   logic [13:0]         next_cfg_word;
   logic                next_serial_out;
   logic                next_valid;
   logic                next_master;
   logic                reinit;       // software restart request
   logic                exp_edge;

   // start of field over the 20 address bits, zero start with valid bit clear if out of range
   function automatic logic [5:0] scl_field_start(input logic [1:0] size,
                                                  input logic [3:0] loc);
      logic [2:0] w;
      logic [3:0] last;
      w = {1'b0, size} + 3'h2;
      case (size)
         2'h0:    last = 4'h9;
         2'h1:    last = 4'h5;
         2'h2:    last = 4'h4;
         default: last = 4'h3;
      endcase
      if (loc > last)
         scl_field_start = 6'h00;
      else
         scl_field_start = {1'b1, 5'(loc * w)};
   endfunction : scl_field_start

   // a toggle of the sampled expansion clock marks a slave
   assign exp_edge = expansion_clock ^ exp_q;
   // register write to ctrl bit0 restarts the reset cycle
   assign reinit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                   && (wb_adr_i == scl_pkg::REG_CTRL) && wb_dat_i[0];

   // sequencer next state
   always_comb
   begin
      next_state      = state;
      next_div_cnt    = div_cnt;
      next_bit_cnt    = bit_cnt;
      next_det_cnt    = det_cnt;
      next_shift      = shift;
      next_cfg_word   = cfg_word;
      next_serial_out = cfg_serial_out;
      next_valid      = cfg_valid;
      next_master     = is_master;
      case (state)
         // first clock after release: still quiet
         scl_pkg::ST_RESET:
         begin
            next_state = scl_pkg::ST_SETTLE;
         end
         // second clock: reset cycle complete after this
         scl_pkg::ST_SETTLE:
         begin
            next_state   = scl_pkg::ST_DETECT;
            next_det_cnt = '0;
         end
         // look for a running expansion clock
         scl_pkg::ST_DETECT:
         begin
            next_det_cnt = det_cnt + DW'(1);
            if (exp_edge)
            begin
               next_state  = scl_pkg::ST_HUNT;
               next_master = 1'b0;
            end
            else if (det_cnt == DW'(DETECT_CYCLES - 1))
            begin
               next_state  = scl_pkg::ST_LOAD;
               next_master = 1'b1;
            end
         end
         // master: parallel strap capture, start bit goes out
         scl_pkg::ST_LOAD:
         begin
            next_cfg_word   = exp_straps;
            next_shift      = exp_straps;
            next_serial_out = 1'b0;
            next_div_cnt    = '0;
            next_bit_cnt    = '0;
            next_valid      = 1'b1;
            next_state      = scl_pkg::ST_TX;
         end
         // master: each level stands five clocks
         scl_pkg::ST_TX:
         begin
            next_div_cnt = div_cnt + 3'h1;
            if (div_cnt == 3'(scl_pkg::BIT_CYCLES - 1))
            begin
               next_div_cnt = '0;
               if (bit_cnt == 4'(scl_pkg::CFG_BITS))
               begin
                  next_serial_out = scl_pkg::SER_IDLE;
                  next_state      = scl_pkg::ST_DONE;
               end
               else
               begin
                  next_serial_out = shift[13];
                  next_shift      = {shift[12:0], 1'b0};
                  next_bit_cnt    = bit_cnt + 4'h1;
               end
            end
         end
         // slave: wait for the line to fall; master never gets here
         scl_pkg::ST_HUNT:
         begin
            next_div_cnt = '0;
            if (!cfg_serial_in)
               next_state = scl_pkg::ST_START;
         end
         // slave: line must stay low up to the bit centre
         scl_pkg::ST_START:
         begin
            next_div_cnt = div_cnt + 3'h1;
            if (cfg_serial_in)
               next_state = scl_pkg::ST_HUNT;
            else if (div_cnt == 3'(scl_pkg::HALF_CYCLES - 1))
            begin
               next_state   = scl_pkg::ST_RX;
               next_div_cnt = '0;
               next_bit_cnt = '0;
            end
         end
         // slave: sample at each following bit centre
         scl_pkg::ST_RX:
         begin
            next_div_cnt = div_cnt + 3'h1;
            if (div_cnt == 3'(scl_pkg::BIT_CYCLES - 1))
            begin
               next_div_cnt = '0;
               next_shift   = {shift[12:0], cfg_serial_in};
               next_bit_cnt = bit_cnt + 4'h1;
               if (bit_cnt == 4'(scl_pkg::CFG_BITS - 1))
               begin
                  next_cfg_word = {shift[12:0], cfg_serial_in};
                  next_valid    = 1'b1;
                  next_state    = scl_pkg::ST_DONE;
               end
            end
         end
         // configured: serial input no longer looked at
         scl_pkg::ST_DONE:
         begin
            next_state = scl_pkg::ST_DONE;
         end
         default:
         begin
            next_state = scl_pkg::ST_RESET;
         end
      endcase
      // a software restart behaves like a reset pulse
      if (reinit)
      begin
         next_state      = scl_pkg::ST_RESET;
         next_cfg_word   = '0;
         next_valid      = 1'b0;
         next_master     = 1'b0;
         next_serial_out = scl_pkg::SER_IDLE;
      end
   end

   // sequencer registers; reset is sampled on the clock
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state          <= scl_pkg::ST_RESET;
         div_cnt        <= '0;
         bit_cnt        <= '0;
         det_cnt        <= '0;
         exp_q          <= 1'b0;
         shift          <= '0;
         cfg_word       <= '0;
         cfg_serial_out <= scl_pkg::SER_IDLE;
         cfg_valid      <= 1'b0;
         is_master      <= 1'b0;
      end
      else
      begin
         state          <= next_state;
         div_cnt        <= next_div_cnt;
         bit_cnt        <= next_bit_cnt;
         det_cnt        <= next_det_cnt;
         exp_q          <= expansion_clock;
         shift          <= next_shift;
         cfg_word       <= next_cfg_word;
         cfg_serial_out <= next_serial_out;
         cfg_valid      <= next_valid;
         is_master      <= next_master;
      end
   end

   // decode of the settings; all inactive until configured
   logic [5:0] dec_start;
   logic [2:0] next_width;
   logic [4:0] next_start;
   logic       next_fvalid;
   logic [5:0] next_col;
   logic [6:0] next_lowq;
   logic [6:0] next_highq;
   logic       next_note;
   logic [6:0] next_pct;
   logic       next_uto;
   logic       next_ven;

   always_comb
   begin
      dec_start   = scl_field_start(cfg_word[scl_pkg::SIZE_LSB +: 2],
                                    cfg_word[scl_pkg::LOC_LSB +: 4]);
      next_width  = '0;
      next_start  = '0;
      next_fvalid = 1'b0;
      next_col    = '0;
      next_lowq   = '0;
      next_highq  = '0;
      next_note   = 1'b0;
      next_pct    = '0;
      next_uto    = 1'b0;
      next_ven    = 1'b0;
      if (cfg_valid)
      begin
         next_width  = {1'b0, cfg_word[scl_pkg::SIZE_LSB +: 2]} + 3'h2;
         next_start  = dec_start[4:0];
         next_fvalid = dec_start[5];
         next_col    = {1'b0, cfg_word[scl_pkg::COL_LSB +: 3], 2'b00} + 6'h01;
         // split queue unless the bit disables it
         if (cfg_word[scl_pkg::SPLIT_BIT])
         begin
            next_lowq  = scl_pkg::SINGLE_Q;
            next_highq = '0;
         end
         else
         begin
            next_lowq  = scl_pkg::LOW_SPLIT;
            next_highq = scl_pkg::HIGH_SPLIT;
         end
         next_note = cfg_word[scl_pkg::NOTE_BIT];
         case (cfg_word[scl_pkg::THR_LSB +: 2])
            2'h1:    next_pct = scl_pkg::PCT_20;
            2'h2:    next_pct = scl_pkg::PCT_50;
            2'h3:    next_pct = scl_pkg::PCT_80;
            default: next_pct = '0;
         endcase
         next_uto = cfg_word[scl_pkg::MODE_BIT];
         next_ven = !cfg_word[scl_pkg::MODE_BIT];
      end
   end

   // decode registers, so every output comes from a flip-flop
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         field_width          <= '0;
         field_start          <= '0;
         field_valid          <= 1'b0;
         column_first         <= '0;
         low_queue_cells      <= '0;
         high_queue_cells     <= '0;
         congestion_notify_en <= 1'b0;
         threshold_pct        <= '0;
         utopia_stream_mode   <= 1'b0;
         vendor_stream_mode   <= 1'b0;
         out_on_falling       <= 1'b0;
      end
      else
      begin
         field_width          <= next_width;
         field_start          <= next_start;
         field_valid          <= next_fvalid;
         column_first         <= next_col;
         low_queue_cells      <= next_lowq;
         high_queue_cells     <= next_highq;
         congestion_notify_en <= next_note;
         threshold_pct        <= next_pct;
         utopia_stream_mode   <= next_uto;
         vendor_stream_mode   <= next_ven;
         out_on_falling       <= next_ven;
      end
   end

   // wishbone: one wait state, unmapped reads give zero
   logic [31:0] next_rdata;
   logic        next_ack;

   always_comb
   begin
      next_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_rdata = '0;
      case (wb_adr_i)
         scl_pkg::REG_STATUS: next_rdata = {24'h0, state, 1'b0, is_master, cfg_valid, cfg_serial_out};
         scl_pkg::REG_CONFIG: next_rdata = {18'h0, cfg_word};
         scl_pkg::REG_DECODE: next_rdata = {10'h0, column_first, field_valid, field_start,
                                            field_width, threshold_pct};
         default:             next_rdata = '0;
      endcase
   end

   // bus answer registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_rdata;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence start_low_s;
      !cfg_serial_out [*5];
   endsequence
   sequence settle_s;
      state == scl_pkg::ST_RESET ##1 state == scl_pkg::ST_SETTLE ##1 state == scl_pkg::ST_DETECT;
   endsequence

   reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> cfg_serial_out && !cfg_valid)
      else $error("outputs not idle after reset");
   reset_cycle_a: assert property ($rose(rst_n) |-> settle_s)
      else $error("reset cycle not two clocks");
   role_slave_a: assert property (state == scl_pkg::ST_DETECT && exp_edge |=> state == scl_pkg::ST_HUNT)
      else $error("clocked expansion pin not slave");
   strap_load_a: assert property (state == scl_pkg::ST_LOAD && !reinit |=> cfg_word == $past(exp_straps))
      else $error("straps not captured");
   start_bit_a: assert property (state == scl_pkg::ST_LOAD && !reinit |=> start_low_s)
      else $error("start bit not five clocks low");
   bit_edge_a: assert property (state == scl_pkg::ST_TX && $changed(cfg_serial_out) |-> div_cnt == 3'h0)
      else $error("serial level changed mid bit");
   idle_high_a: assert property (state == scl_pkg::ST_DONE && is_master |-> cfg_serial_out)
      else $error("line not high after frame");
   start_check_a: assert property (state == scl_pkg::ST_START && cfg_serial_in && !reinit
                                   |=> state == scl_pkg::ST_HUNT)
      else $error("false start accepted");
   rx_pace_a: assert property (state == scl_pkg::ST_RX && $changed(bit_cnt) |-> $past(div_cnt) == 3'h4)
      else $error("receive sample off the bit centre");
   rx_ignore_a: assert property (state == scl_pkg::ST_DONE && !reinit |=> $stable(cfg_word))
      else $error("configuration changed after done");
endmodule : scl_loader

// File: test/scl_pld_model.sv
/*
 * serial sender standing in for a master or a programmable part that
 * feeds a slave loader; can also throw a one-cycle false start.
 * assumes go and glitch are one-cycle pulses from the bench.
 */
module scl_pld_model (
   input  wire logic        sys_clk,
   input  wire logic        go,
   input  wire logic        glitch,
   input  wire logic [13:0] word,
   output logic             line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] shift; // start bit, settings, idle
   logic [4:0]  nbits; // bit periods still to send
   logic [2:0]  phase; // clock within a bit period
   initial nbits = 5'h00;
   // one bit each five clocks, start bit low first, msb first
   always @(posedge sys_clk)
   begin
      if (go)
      begin
         shift <= {1'b0, word, 1'b1};
         nbits <= 5'h10;
         phase <= 3'h0;
      end
      else if (glitch)
      begin
         // short low pulse a slave has to reject
         shift <= 16'h7fff;
         nbits <= 5'h01;
         phase <= 3'h4;
      end
      else if (nbits != 5'h00)
      begin
         if (phase == 3'h4)
         begin
            phase <= 3'h0;
            shift <= {shift[14:0], 1'b1};
            nbits <= nbits - 5'h01;
         end
         else
            phase <= phase + 3'h1;
      end
   end
   // pulled high whenever nothing is sent
   assign line = (nbits != 5'h00) ? shift[15] : 1'b1;
endmodule : scl_pld_model

// File: test/test_scl_loader.sv
/*
 * self-checking bench of the loader: a strap table checked on the frame
 * and the decode, then reset, register bus and slave cases by hand.
 * assumes one 50 MHz clock and the sender model on the serial input.
 */
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR t=%0t got %h expected %h", $time, (got), (exp)); end end
module test_scl_loader;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [13:0] straps;
      logic [2:0]  w;
      logic [4:0]  st;
      logic        v;
      logic [5:0]  col;
      logic [6:0]  lo;
      logic [6:0]  hi;
      logic        ne;
      logic [6:0]  thr;
      logic        ut;
   } scl_row_t;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        expansion_clock = 1'b0;
   logic        exp_run = 1'b0;   // toggles the expansion clock
   logic        tie_low = 1'b1;   // master input tied low, else idle high from the sender
   logic [13:0] exp_straps = 14'h0000;
   logic        go = 1'b0;
   logic        glitch = 1'b0;
   logic [13:0] tx_word = 14'h0000;
   logic        pld_line;
   logic        cfg_serial_in;    // loader serial input
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        cfg_serial_out, cfg_valid, is_master, field_valid, wb_ack_o;
   logic        congestion_notify_en, utopia_stream_mode, vendor_stream_mode, out_on_falling;
   logic [13:0] cfg_word;
   logic [2:0]  field_width;
   logic [4:0]  field_start;
   logic [5:0]  column_first;
   logic [6:0]  low_queue_cells, high_queue_cells, threshold_pct;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   int          fails = 0;
   int          n_compared = 0;
   int          cycles = 0;
   // straps beside expected decode; every column and threshold code appears
   scl_row_t    rows [8] = '{
      '{14'h0000, 3'h2, 5'h00, 1'b1, 6'h01, 7'h32, 7'h19, 1'b0, 7'h00, 1'b0},
      '{14'h33ff, 3'h5, 5'h0f, 1'b1, 6'h1d, 7'h4b, 7'h00, 1'b1, 7'h50, 1'b1},
      '{14'h0942, 3'h2, 5'h12, 1'b1, 6'h09, 7'h32, 7'h19, 1'b0, 7'h14, 1'b0},
      '{14'h0a74, 3'h2, 5'h00, 1'b0, 6'h0d, 7'h4b, 7'h00, 1'b0, 7'h32, 1'b0},
      '{14'h1589, 3'h3, 5'h0f, 1'b1, 6'h11, 7'h32, 7'h19, 1'b1, 7'h00, 1'b1},
      '{14'h25a0, 3'h4, 5'h00, 1'b0, 6'h15, 7'h32, 7'h19, 1'b0, 7'h00, 1'b0},
      '{14'h34c0, 3'h5, 5'h00, 1'b0, 6'h19, 7'h32, 7'h19, 1'b0, 7'h00, 1'b0},
      '{14'h2420, 3'h4, 5'h10, 1'b1, 6'h05, 7'h32, 7'h19, 1'b0, 7'h00, 1'b0}};
   assign cfg_serial_in = tie_low ? 1'b0 : pld_line;
   scl_loader #(.DETECT_CYCLES(8)) u_scl_loader (.sys_clk(sys_clk), .rst_n(rst_n),
      .expansion_clock(expansion_clock), .exp_straps(exp_straps), .cfg_serial_in(cfg_serial_in),
      .cfg_serial_out(cfg_serial_out), .cfg_valid(cfg_valid), .is_master(is_master),
      .cfg_word(cfg_word), .field_width(field_width), .field_start(field_start),
      .field_valid(field_valid), .column_first(column_first), .low_queue_cells(low_queue_cells),
      .high_queue_cells(high_queue_cells), .congestion_notify_en(congestion_notify_en),
      .threshold_pct(threshold_pct), .utopia_stream_mode(utopia_stream_mode),
      .vendor_stream_mode(vendor_stream_mode), .out_on_falling(out_on_falling),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   scl_pld_model u_scl_pld_model (.sys_clk(sys_clk), .go(go), .glitch(glitch), .word(tx_word),
      .line(pld_line));
   // clock and expansion clock
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      if (exp_run)
         expansion_clock <= ~expansion_clock;
   end
   // hang guard, far above the planned run length
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic clk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : clk
   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      clk(n);
      rst_n <= 1'b1;
   endtask : do_reset
   // one classic cycle, held until ack is seen
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      clk(1);
      // no wait limit here: only the hang guard ends a stuck cycle
      while (wb_ack_o !== 1'b1)
         clk(1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      clk(1);
   endtask : wb_xfer
   // follows a master frame at bit centres, then the decode
   task automatic check_frame(input scl_row_t r);
      int k;
      k = 0;
      clk(1);
      while (cfg_serial_out !== 1'b0 && k < 200)
      begin
         clk(1);
         k++;
      end
      clk(2);
      `CHK(cfg_serial_out, 1'b0)
      for (int i = 13; i >= 0; i--)
      begin
         clk(5);
         `CHK(cfg_serial_out, r.straps[i])
      end
      clk(45);
      `CHK(cfg_serial_out, 1'b1)
      `CHK(is_master, 1'b1)
      `CHK(cfg_word, r.straps)
      `CHK(field_width, r.w)
      `CHK(field_start, r.st)
      `CHK(field_valid, r.v)
      `CHK(column_first, r.col)
      `CHK({low_queue_cells, high_queue_cells}, {r.lo, r.hi})
      `CHK(congestion_notify_en, r.ne)
      `CHK(threshold_pct, r.thr)
      `CHK({utopia_stream_mode, vendor_stream_mode}, {r.ut, ~r.ut})
      `CHK(out_on_falling, ~r.ut)
   endtask : check_frame
   initial
   begin
      // outputs inactive while reset is held
      clk(2);
      `CHK({cfg_serial_out, cfg_valid, wb_ack_o}, 3'b100)
      clk(14);
      rst_n <= 1'b1;
      clk(1);
      $display("test reset done");
      foreach (rows[i])
      begin
         // master serial input alternates between tied low and idle high
         tie_low <= i[0];
         exp_straps <= rows[i].straps;
         do_reset(2);
         check_frame(rows[i]);
      end
      $display("test strap table done");
      // register bus: status, config, decode, unmapped, read-only, restart
      wb_xfer(1'b0, 8'h04, 32'h0);
      `CHK(rd, {24'h000000, scl_pkg::ST_DONE, 4'h7})
      wb_xfer(1'b0, 8'h08, 32'h0);
      `CHK(rd, 32'h00002420)
      wb_xfer(1'b0, 8'h0c, 32'h0);
      `CHK(rd, 32'h0005c200)
      wb_xfer(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h0)
      wb_xfer(1'b1, 8'h04, 32'hffffffff);
      wb_xfer(1'b0, 8'h04, 32'h0);
      `CHK(rd, {24'h000000, scl_pkg::ST_DONE, 4'h7})
      wb_xfer(1'b1, 8'h00, 32'h00000001);
      clk(2);
      `CHK(cfg_valid, 1'b0)
      check_frame(rows[7]);
      $display("test register bus done");
      // reset in mid frame puts the line back high, then a fresh frame
      exp_straps <= rows[1].straps;
      do_reset(1);
      clk(14);
      `CHK(cfg_serial_out, 1'b0)
      do_reset(1);
      clk(2);
      `CHK({cfg_serial_out, cfg_valid}, 2'b10)
      check_frame(rows[1]);
      $display("test mid frame reset done");
      // slave: false start rejected, frame taken, later frame ignored
      tie_low <= 1'b0;
      exp_run <= 1'b1;
      do_reset(2);
      clk(20);
      glitch <= 1'b1;
      clk(1);
      glitch <= 1'b0;
      clk(10);
      tx_word <= 14'h2a5c;
      go <= 1'b1;
      clk(1);
      go <= 1'b0;
      clk(90);
      `CHK({is_master, cfg_valid, cfg_serial_out}, 3'b011)
      `CHK(cfg_word, 14'h2a5c)
      `CHK({congestion_notify_en, threshold_pct}, {1'b1, 7'h32})
      tx_word <= 14'h15a3;
      go <= 1'b1;
      clk(1);
      go <= 1'b0;
      clk(90);
      `CHK(cfg_word, 14'h2a5c)
      $display("test slave receive done");
      end_of_test();
   end
endmodule : test_scl_loader
